// ---- design/tpwm_pkg.sv ----
// Constants shared by the timer/PWM unit: register map, field layout, encodings.
package tpwm_pkg;

  // ==========================================================
  // Sizes
  localparam int NT  = 2;   // Timers: single-channel and four-channel
  localparam int NC  = 5;   // Channels in total
  localparam int CW  = 16;  // Counter, modulus and channel value width
  localparam int PSW = 7;   // Prescaler chain, taps up to divide by 128
  localparam int NS  = 7;   // Status bits: one per channel, one per timer overflow
  localparam int T0_CHANNELS = 1; // Channels below this index belong to timer 0

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] TMR_STRIDE = 8'h10;
  localparam logic [7:0] OFF_SC     = 8'h00;
  localparam logic [7:0] OFF_CNT    = 8'h04;
  localparam logic [7:0] OFF_MOD    = 8'h08;
  localparam logic [7:0] CH_BASE    = 8'h20;
  localparam logic [7:0] CH_STRIDE  = 8'h08;
  localparam logic [7:0] OFF_CSC    = 8'h00;
  localparam logic [7:0] OFF_CV     = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h48;
  localparam logic [7:0] A_MASK     = 8'h4C;

  // ==========================================================
  // Field positions
  localparam int SC_PS_LSB   = 0;  // 3 bits, divide by 2**ps
  localparam int SC_SRC_LSB  = 3;  // 2 bits
  localparam int SC_CENTER_ALIGNED_PWM_BIT = 5;
  localparam int CSC_MODE_LSB = 0; // 2 bits
  localparam int CSC_SEL_LSB  = 2; // 2 bits
  localparam int ST_TOF_LSB   = NC;

  // ==========================================================
  // Encodings
  localparam logic [1:0] SRC_OFF   = 2'h0;
  localparam logic [1:0] SRC_BUS   = 2'h1;
  localparam logic [1:0] SRC_FIXED = 2'h2;
  localparam logic [1:0] SRC_EXT   = 2'h3;
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_CAP  = 2'h1;
  localparam logic [1:0] MODE_CMP  = 2'h2;
  localparam logic [1:0] MODE_PWM  = 2'h3;
  localparam logic [1:0] ACT_CLEAR = 2'h1;
  localparam logic [1:0] ACT_SET   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam int SEL_RISE_BIT = 0; // Capture on rising edge
  localparam int SEL_FALL_BIT = 1; // Capture on falling edge
  localparam int SEL_LOW_BIT  = 0; // PWM low-true pulses

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// ---- design/tpwm_sync.sv ----
// Two-flop synchroniser for the pins that enter the timer clock domain.
`timescale 1ns/10ps
module tpwm_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // Bus clock
  input  wire logic         presetn, // Asynchronous reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised inputs
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tpwm_sync_s;

  tpwm_sync_s s;
  tpwm_sync_s next_s;

  // First stage is read only by the second stage
  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;

endmodule

// ---- design/tpwm_top.sv ----
// Timer/PWM unit: two timers, five capture/compare/PWM channels, APB registers.
`timescale 1ns/10ps

// What this block does
// R1: Each channel independently does input capture, output compare or edge-aligned PWM.
// R2: One bit per timer forces all its channels that are not off into center-aligned PWM.
// R3: 16-bit counter counts up freely, or up then down in center mode.
// R4: A 16-bit modulus sets the counter range and overflow period.
// R5: Software picks prescale divide by 1, 2, 4, 8, 16, 32, 64 or 128.
// R6: Each timer picks bus clock, fixed system clock or external pin.
// R7: Software uses fixed clock only when clock generator runs from external clock.
// R8: Capture latches the counter on rising, falling or either pin edge.
// R9: Compare match sets, clears or toggles the channel pin.
// R10: PWM output polarity is selectable, high-true or low-true.
// R11: One interrupt per channel event plus one per timer overflow.
// R12: Two timers: one with one channel, one with four.
// R13: Each channel owns one shared port pin while it is in use.
// R14: In loop-bypassed external mode the fixed clock is the external source.
// R15: Buffered duty and modulus take effect only at a period boundary, or at once while the timer has no clock source.
// R16: With no clock source the counter holds and no events occur.
module tpwm_top (
  input  wire logic                      pclk,      // Bus clock
  input  wire logic                      presetn,   // Asynchronous reset, active low
  input  wire logic                      psel,      // APB select
  input  wire logic                      penable,   // APB access phase
  input  wire logic                      pwrite,    // APB write
  input  wire logic [7:0]                paddr,     // APB byte address
  input  wire logic [31:0]               pwdata,    // APB write data
  output logic      [31:0]               prdata,    // APB read data
  output logic                           pready,    // APB ready
  output logic                           pslverr,   // APB error, unmapped address
  input  wire logic [tpwm_pkg::NC-1:0]   timer_channel_pin_in,  // Pin levels
  output logic      [tpwm_pkg::NC-1:0]   timer_channel_pin_out, // Pin drive level
  output logic      [tpwm_pkg::NC-1:0]   timer_channel_pin_oe,  // Timer drives pin
  output logic      [tpwm_pkg::NC-1:0]   timer_channel_pin_own, // Timer owns pin
  input  wire logic                      fixed_system_clock,    // Fixed-rate clock
  input  wire logic [tpwm_pkg::NT-1:0]   ext_clk_pin,           // External clock per timer
  output logic                           irq        // Level interrupt
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [tpwm_pkg::NT-1:0][tpwm_pkg::CW-1:0]  cnt;
    logic [tpwm_pkg::NT-1:0][tpwm_pkg::CW-1:0]  mod_act;
    logic [tpwm_pkg::NT-1:0][tpwm_pkg::CW-1:0]  mod_buf;
    logic [tpwm_pkg::NT-1:0]                    down;
    logic [tpwm_pkg::NT-1:0]                    center_aligned_pwm;
    logic [tpwm_pkg::NT-1:0][tpwm_pkg::PSW-1:0] pre;
    logic [tpwm_pkg::NT-1:0][2:0]               ps;
    logic [tpwm_pkg::NT-1:0][1:0]               src;
    logic [tpwm_pkg::NC-1:0][1:0]               mode;
    logic [tpwm_pkg::NC-1:0][1:0]               sel;
    logic [tpwm_pkg::NC-1:0][tpwm_pkg::CW-1:0]  cv_buf;
    logic [tpwm_pkg::NC-1:0][tpwm_pkg::CW-1:0]  cv_act;
    logic [tpwm_pkg::NC-1:0]                    out;
    logic [tpwm_pkg::NC-1:0]                    oe;
    logic [tpwm_pkg::NC-1:0]                    own;
    logic [tpwm_pkg::NC-1:0]                    pin_d;
    logic                                       fix_d;
    logic [tpwm_pkg::NT-1:0]                    ext_d;
    logic [tpwm_pkg::NS-1:0]                    status;
    logic [tpwm_pkg::NS-1:0]                    mask;
    logic [31:0]                                prdata;
    logic                                       pready;
    logic                                       pslverr;
    logic                                       irq;
  } tpwm_state_s;

  tpwm_state_s s;
  tpwm_state_s next_s;

  // ==========================================================
  // Pin synchronisers
  logic [tpwm_pkg::NC-1:0] pin_q;
  logic                    fix_q;
  logic [tpwm_pkg::NT-1:0] ext_q;

  tpwm_sync #(
    .W (tpwm_pkg::NC + 1 + tpwm_pkg::NT)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({ext_clk_pin, fixed_system_clock, timer_channel_pin_in}),
    .q       ({ext_q, fix_q, pin_q})
  );

  // ==========================================================
  // Next state
  logic [tpwm_pkg::NT-1:0]     tick;
  logic [tpwm_pkg::NT-1:0]     cnt_en;
  logic [tpwm_pkg::NT-1:0]     bnd;
  logic [tpwm_pkg::NT-1:0]     run;
  logic [tpwm_pkg::NS-1:0]     ev;
  logic [tpwm_pkg::PSW-1:0]    pmask;
  logic [tpwm_pkg::CW-1:0]     lim;
  logic [1:0]                  md;
  logic                        rise;
  logic                        fall;
  logic                        wr;
  logic                        rd;
  logic                        hit;
  logic [7:0]                  base;
  int                          t;

  always_comb begin
    next_s         = s;
    tick           = '0;
    cnt_en         = '0;
    bnd            = '0;
    run            = '0;
    ev             = '0;
    pmask          = '0;
    lim            = '0;
    md             = tpwm_pkg::MODE_OFF;
    rise           = 1'b0;
    fall           = 1'b0;
    hit            = 1'b0;
    base           = '0;
    t              = 0;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.pin_d   = pin_q;
    next_s.fix_d   = fix_q;
    next_s.ext_d   = ext_q;
    wr = psel && penable && pwrite && s.pready;
    rd = psel && !penable;

    // Counters, one per timer
    for (int i = 0; i < tpwm_pkg::NT; i++) begin
      run[i] = (s.src[i] != tpwm_pkg::SRC_OFF);                              // [R16]
      case (s.src[i])                                                        // [R6]
        tpwm_pkg::SRC_BUS:   tick[i] = 1'b1;
        tpwm_pkg::SRC_FIXED: tick[i] = fix_q && !s.fix_d;                    // [R14]
        tpwm_pkg::SRC_EXT:   tick[i] = ext_q[i] && !s.ext_d[i];
        default:             tick[i] = 1'b0;
      endcase
      // Prescale: count once every 2**ps source ticks
      pmask     = ~({tpwm_pkg::PSW{1'b1}} << s.ps[i]);                       // [R5]
      cnt_en[i] = tick[i] && ((s.pre[i] & pmask) == pmask);
      if (tick[i]) begin
        next_s.pre[i] = s.pre[i] + 1'b1;
      end
      // A zero modulus leaves the counter free-running over the full range
      lim = (s.mod_act[i] == '0) ? {tpwm_pkg::CW{1'b1}} : s.mod_act[i];      // [R4]
      if (cnt_en[i]) begin
        if (!s.center_aligned_pwm[i]) begin                                                // [R3]
          if (s.cnt[i] >= lim) begin
            next_s.cnt[i] = '0;
            bnd[i]        = 1'b1;
          end else begin
            next_s.cnt[i] = s.cnt[i] + 1'b1;
          end
        end else if (s.down[i]) begin                                        // [R3]
          if (s.cnt[i] == '0) begin
            next_s.down[i] = 1'b0;
            next_s.cnt[i]  = s.cnt[i] + 1'b1;
            bnd[i]         = 1'b1;
          end else begin
            next_s.cnt[i] = s.cnt[i] - 1'b1;
          end
        end else begin
          if (s.cnt[i] >= lim) begin
            next_s.down[i] = 1'b1;
            next_s.cnt[i]  = s.cnt[i] - 1'b1;
          end else begin
            next_s.cnt[i] = s.cnt[i] + 1'b1;
          end
        end
      end
      // New period only from a boundary or while the clock source is off, so no period is cut short
      if (bnd[i] || !run[i]) begin
        next_s.mod_act[i] = s.mod_buf[i];                                    // [R15]
      end
      ev[tpwm_pkg::ST_TOF_LSB + i] = bnd[i];                                 // [R11]
    end

    // Channels
    for (int c = 0; c < tpwm_pkg::NC; c++) begin
      t  = (c < tpwm_pkg::T0_CHANNELS) ? 0 : 1;                              // [R12]
      md = s.mode[c];                                                        // [R1]
      if (s.center_aligned_pwm[t] && s.mode[c] != tpwm_pkg::MODE_OFF) begin
        md = tpwm_pkg::MODE_PWM;                                             // [R2]
      end
      rise = pin_q[c] && !s.pin_d[c];
      fall = !pin_q[c] && s.pin_d[c];
      case (md)
        tpwm_pkg::MODE_CAP: begin
          if (run[t] && ((s.sel[c][tpwm_pkg::SEL_RISE_BIT] && rise) ||
                         (s.sel[c][tpwm_pkg::SEL_FALL_BIT] && fall))) begin   // [R8]
            next_s.cv_act[c] = s.cnt[t];
            ev[c]            = 1'b1;                                         // [R11]
          end
        end
        tpwm_pkg::MODE_CMP: begin
          next_s.cv_act[c] = s.cv_buf[c];
          if (cnt_en[t] && s.cnt[t] == s.cv_act[c]) begin
            ev[c] = 1'b1;                                                    // [R11]
            case (s.sel[c])                                                  // [R9]
              tpwm_pkg::ACT_CLEAR:  next_s.out[c] = 1'b0;
              tpwm_pkg::ACT_SET:    next_s.out[c] = 1'b1;
              tpwm_pkg::ACT_TOGGLE: next_s.out[c] = !s.out[c];
              default:              next_s.out[c] = s.out[c];
            endcase
          end
        end
        tpwm_pkg::MODE_PWM: begin
          // Duty at or above the period gives a steady active level
          next_s.out[c] = (s.cnt[t] < s.cv_act[c]) ^
                          s.sel[c][tpwm_pkg::SEL_LOW_BIT];                   // [R10]
          if (bnd[t] || !run[t]) begin
            next_s.cv_act[c] = s.cv_buf[c];                                  // [R15]
          end
          ev[c] = bnd[t];                                                    // [R11]
        end
        default: begin
          next_s.cv_act[c] = s.cv_buf[c];
          next_s.out[c]    = 1'b0;
        end
      endcase
      next_s.oe[c]  = (md == tpwm_pkg::MODE_CMP) || (md == tpwm_pkg::MODE_PWM); // [R13]
      next_s.own[c] = (md != tpwm_pkg::MODE_OFF);                             // [R13]
    end

    // ==========================================================
    // Register writes, taken at the end of the access phase
    if (wr) begin
      for (int i = 0; i < tpwm_pkg::NT; i++) begin
        base = 8'(i) * tpwm_pkg::TMR_STRIDE;
        if (paddr == base + tpwm_pkg::OFF_SC) begin
          next_s.ps[i]   = pwdata[tpwm_pkg::SC_PS_LSB +: 3];
          next_s.src[i]  = pwdata[tpwm_pkg::SC_SRC_LSB +: 2];
          next_s.center_aligned_pwm[i] = pwdata[tpwm_pkg::SC_CENTER_ALIGNED_PWM_BIT];
        end
        if (paddr == base + tpwm_pkg::OFF_CNT) begin
          next_s.cnt[i]  = '0;
          next_s.down[i] = 1'b0;
          next_s.pre[i]  = '0;
        end
        if (paddr == base + tpwm_pkg::OFF_MOD) begin
          next_s.mod_buf[i] = pwdata[tpwm_pkg::CW-1:0];
        end
      end
      for (int c = 0; c < tpwm_pkg::NC; c++) begin
        base = tpwm_pkg::CH_BASE + 8'(c) * tpwm_pkg::CH_STRIDE;
        if (paddr == base + tpwm_pkg::OFF_CSC) begin
          next_s.mode[c] = pwdata[tpwm_pkg::CSC_MODE_LSB +: 2];
          next_s.sel[c]  = pwdata[tpwm_pkg::CSC_SEL_LSB +: 2];
        end
        if (paddr == base + tpwm_pkg::OFF_CV) begin
          next_s.cv_buf[c] = pwdata[tpwm_pkg::CW-1:0];
        end
      end
      if (paddr == tpwm_pkg::A_STATUS) begin
        next_s.status = s.status & ~pwdata[tpwm_pkg::NS-1:0];
      end
      if (paddr == tpwm_pkg::A_MASK) begin
        next_s.mask = pwdata[tpwm_pkg::NS-1:0];
      end
    end
    // A new event wins over a clear in the same cycle
    next_s.status = next_s.status | ev;                                       // [R11]
    next_s.irq    = |(next_s.status & next_s.mask);

    // ==========================================================
    // Register reads, captured in the setup phase
    if (rd) begin
      next_s.pready = 1'b1;
      next_s.prdata = tpwm_pkg::RST_ZERO;
      for (int i = 0; i < tpwm_pkg::NT; i++) begin
        base = 8'(i) * tpwm_pkg::TMR_STRIDE;
        if (paddr == base + tpwm_pkg::OFF_SC) begin
          hit = 1'b1;
          next_s.prdata[tpwm_pkg::SC_PS_LSB +: 3]  = s.ps[i];
          next_s.prdata[tpwm_pkg::SC_SRC_LSB +: 2] = s.src[i];
          next_s.prdata[tpwm_pkg::SC_CENTER_ALIGNED_PWM_BIT]     = s.center_aligned_pwm[i];
        end
        if (paddr == base + tpwm_pkg::OFF_CNT) begin
          hit = 1'b1;
          next_s.prdata[tpwm_pkg::CW-1:0] = s.cnt[i];
        end
        if (paddr == base + tpwm_pkg::OFF_MOD) begin
          hit = 1'b1;
          next_s.prdata[tpwm_pkg::CW-1:0] = s.mod_buf[i];
        end
      end
      for (int c = 0; c < tpwm_pkg::NC; c++) begin
        base = tpwm_pkg::CH_BASE + 8'(c) * tpwm_pkg::CH_STRIDE;
        if (paddr == base + tpwm_pkg::OFF_CSC) begin
          hit = 1'b1;
          next_s.prdata[tpwm_pkg::CSC_MODE_LSB +: 2] = s.mode[c];
          next_s.prdata[tpwm_pkg::CSC_SEL_LSB +: 2]  = s.sel[c];
        end
        if (paddr == base + tpwm_pkg::OFF_CV) begin
          hit = 1'b1;
          // Capture mode reads the latched count, other modes the buffer
          next_s.prdata[tpwm_pkg::CW-1:0] =
            (s.mode[c] == tpwm_pkg::MODE_CAP) ? s.cv_act[c] : s.cv_buf[c];
        end
      end
      if (paddr == tpwm_pkg::A_STATUS) begin
        hit = 1'b1;
        next_s.prdata[tpwm_pkg::NS-1:0] = s.status;
      end
      if (paddr == tpwm_pkg::A_MASK) begin
        hit = 1'b1;
        next_s.prdata[tpwm_pkg::NS-1:0] = s.mask;
      end
      next_s.pslverr = !hit;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign timer_channel_pin_out = s.out;
  assign timer_channel_pin_oe  = s.oe;
  assign timer_channel_pin_own = s.own;
  assign irq                   = s.irq;

endmodule

// ---- bench/tpwm_top_assertions.sv ----
// Checker for the timer/PWM unit bus answers, pin ownership and interrupt.
`timescale 1ns/10ps
module tpwm_top_assertions (
  input wire logic                    pclk,                  // Clock
  input wire logic                    presetn,               // Reset, active low
  input wire logic                    psel,                  // APB select
  input wire logic                    penable,               // APB access
  input wire logic                    pwrite,                // APB write
  input wire logic [7:0]              paddr,                 // APB address
  input wire logic [31:0]             prdata,                // APB read data
  input wire logic                    pready,                // APB ready
  input wire logic                    pslverr,               // APB error
  input wire logic [tpwm_pkg::NC-1:0] timer_channel_pin_oe,  // Pin drive
  input wire logic [tpwm_pkg::NC-1:0] timer_channel_pin_own, // Pin owned
  input wire logic                    irq                    // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus answers
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");
  property p_err_with_ready;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_unmapped;
    psel && !penable && paddr > 8'h4C |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");
  property p_unaligned;
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned address accepted");
  property p_status_ok;
    psel && !penable && paddr == 8'h48 |=> !pslverr;
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("status access refused");
  // ==========================================================
  // Pins and interrupt
  property p_oe_owned;
    (timer_channel_pin_oe & ~timer_channel_pin_own) == 5'h00;
  endproperty
  a_oe_owned: assert property (p_oe_owned) else $error("pin driven but not owned");
  property p_irq_fall;
    $fell(irq) |-> ($past(pwrite) && $past(penable)) || ($past(pwrite, 2) && $past(penable, 2));
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
endmodule

bind tpwm_top tpwm_top_assertions u_tpwm_top_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .timer_channel_pin_oe, .timer_channel_pin_own,
  .irq);

// ---- bench/tpwm_pin_model.sv ----
// Far-side model: channel pin levels and the external and fixed clock pins.
`timescale 1ns/10ps
module tpwm_pin_model (
  input  wire logic                    pclk,               // Bus clock
  input  wire logic [tpwm_pkg::NC-1:0] pin_out,            // Timer drive level
  input  wire logic [tpwm_pkg::NC-1:0] pin_oe,             // Timer drive enable
  output logic      [tpwm_pkg::NC-1:0] pin_in,             // Resolved pin level
  output logic                         fixed_system_clock, // Fixed-rate clock
  output logic      [tpwm_pkg::NT-1:0] ext_clk_pin         // External clocks
);
  logic [tpwm_pkg::NC-1:0] level = 5'h00;
  logic [2:0]              clk_lvl = 3'h0;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
  // Clocks stand still between ticks, so every count is exact
  assign fixed_system_clock = clk_lvl[2];
  assign ext_clk_pin = clk_lvl[1:0];
  task drive(input int b, input logic v);
    @(posedge pclk);
    level[b] <= v;
  endtask
  task tick(input int k);
    @(posedge pclk);
    clk_lvl[k] <= 1'b1;
    repeat (4) @(posedge pclk);
    clk_lvl[k] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ---- bench/timer_pwm_capture_compare_tb.sv ----
// Self-checking bench for the timer/PWM unit.
`timescale 1ns/10ps
module timer_pwm_capture_compare_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  pin_in;
  logic [4:0]  pin_out;
  logic [4:0]  pin_oe;
  logic [4:0]  pin_own;
  logic        fix_clk;
  logic [1:0]  ext_clk;
  logic        irq;
  logic        err_seen;
  logic [31:0] rd;
  int          errors = 0;
  int          samples_checked = 0;
  int          hi;
  int          tg;

  always #20 pclk = ~pclk;

  tpwm_top u_tpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_channel_pin_in(pin_in), .timer_channel_pin_out(pin_out),
    .timer_channel_pin_oe(pin_oe), .timer_channel_pin_own(pin_own),
    .fixed_system_clock(fix_clk), .ext_clk_pin(ext_clk), .irq(irq));
  tpwm_pin_model u_tpwm_pin_model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .fixed_system_clock(fix_clk), .ext_clk_pin(ext_clk));

  // ==========================================================
  // Shared tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) errors++;
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Counts high cycles and level changes of one channel output
  task automatic watch(input int b, input int n);
    logic p;
    hi = 0;
    tg = 0;
    p = pin_out[b];
    repeat (n) begin
      @(posedge pclk);
      hi += (pin_out[b] === 1'b1);
      tg += (pin_out[b] !== p);
      p = pin_out[b];
    end
  endtask
  task wrap_up;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    chk(pin_own, 5'h00);
    chk(irq, 1'b0);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk(err_seen, 1'b1);
    apb(1'b1, 8'h51, 32'hFFFF_FFFF);
    chk(err_seen, 1'b1);
  endtask
  task t_ext;
    apb(1'b1, 8'h20, 32'h5);
    cyc(2);
    chk(pin_own[0], 1'b1);
    chk(pin_oe[0], 1'b0);
    for (int ps = 0; ps < 3; ps++) begin
      apb(1'b1, 8'h00, 32'h18 | ps);
      apb(1'b1, 8'h04, 32'h0);
      repeat (4) u_tpwm_pin_model.tick(0);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h4 >> ps);
    end
    apb(1'b1, 8'h00, 32'h18);
    apb(1'b1, 8'h04, 32'h0);
    repeat (5) u_tpwm_pin_model.tick(0);
    u_tpwm_pin_model.drive(0, 1'b1);
    cyc(8);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, 8'h48, 32'h1);
    u_tpwm_pin_model.drive(0, 1'b0);
    cyc(8);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b1, 8'h04, 32'h0);
    repeat (4) u_tpwm_pin_model.tick(2);
    apb(1'b1, 8'h00, 32'h0);
    repeat (2) u_tpwm_pin_model.tick(2);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
  endtask
  task t_cmp;
    apb(1'b1, 8'h18, 32'h9);
    apb(1'b1, 8'h2C, 32'h3);
    apb(1'b1, 8'h28, 32'hA);
    apb(1'b1, 8'h10, 32'h8);
    cyc(30);
    chk(pin_out[1], 1'b1);
    chk(pin_oe[1], 1'b1);
    apb(1'b1, 8'h4C, 32'h2);
    cyc(3);
    chk(irq, 1'b1);
    apb(1'b1, 8'h28, 32'h6);
    cyc(30);
    chk(pin_out[1], 1'b0);
    apb(1'b1, 8'h28, 32'hE);
    cyc(12);
    watch(1, 100);
    chk(tg, 10);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h42);
    apb(1'b1, 8'h4C, 32'h0);
    cyc(3);
    chk(irq, 1'b0);
    apb(1'b1, 8'h48, 32'h7F);
    cyc(20);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_pwm;
    apb(1'b1, 8'h34, 32'h4);
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h10, 32'h8);
    cyc(20);
    watch(2, 100);
    chk(hi, 40);
    apb(1'b1, 8'h30, 32'h7);
    cyc(20);
    watch(2, 100);
    chk(hi, 60);
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h34, 32'h7);
    cyc(20);
    watch(2, 100);
    chk(hi, 70);
    // Compare mode on purpose: the center bit must force PWM
    apb(1'b1, 8'h10, 32'h28);
    apb(1'b1, 8'h30, 32'h2);
    cyc(40);
    watch(2, 180);
    chk(hi, 130);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ext;
    t_cmp;
    t_pwm;
    wrap_up;
  end

  initial begin
    #400000;
    errors++;
    wrap_up;
  end
endmodule
